/* hw/isvp_pkg.sv */
// Purpose: Shared constants and types for the interrupt source vector prioritizer.
// Assumes: 8-bit register port with one-cycle read latency.
// Notes: Offsets index 8-bit registers on the plain register port.
package isvp_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [2:0] OFF_SYSTEM_CONTROL = 3'h0;
    localparam logic [2:0] OFF_EXT_SENSE = 3'h1;
    localparam logic [2:0] OFF_EXT_ENABLE = 3'h2;
    localparam logic [2:0] OFF_EXT_STATUS = 3'h3;
    localparam logic [2:0] OFF_PRIORITY_A = 3'h4;
    localparam logic [2:0] OFF_PRIORITY_B = 3'h5;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int BIT_USER_MASK_ENABLE = 3;
    localparam int BIT_NMI_EDGE_SELECT = 2;
    localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h08;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] EXT_LINE_MASK = 8'h3f;
    localparam int NUM_EXT = 6;
    localparam int NUM_INT = 30;

    // ****************************************
    // Vector numbers
    // ****************************************
    localparam logic [7:0] VEC_NMI = 8'h07;
    localparam logic [7:0] VEC_EXT_BASE = 8'h0c;
    localparam logic [7:0] VEC_WATCHDOG = 8'h14;
    localparam logic [7:0] VEC_REFRESH = 8'h15;
    localparam logic [7:0] VEC_TIMER_BASE = 8'h18;
    localparam logic [7:0] VEC_TRANSFER_BASE = 8'h2c;
    localparam logic [7:0] VEC_SERIAL_BASE = 8'h34;
    localparam logic [7:0] VEC_ADC = 8'h3c;

    // Internal sources that may be steered to the transfer controller.
    localparam logic [29:0] ROUTABLE_MASK = 30'h1fe1fffc;

    typedef struct packed {
        logic valid;
        logic level;
        logic [7:0] vector;
    } isvp_pick_s;
endpackage

/* hw/isvp_top.sv */
// How it works
// R1 - NMI, six external, thirty internal sources.
// R2 - Only NMI and lines 0-2 wake standby.
// R3 - NMI always wins, unmasked, vector 7.
// R4 - Edge select bit picks NMI edge polarity.
// R5 - Sense bit picks low level or falling edge.
// R6 - Disabled external lines never reach selection.
// R7 - Priority A bits 7..4 serve external lines.
// R8 - Status shows line requests; software clears.
// R9 - External lines use vectors 12 to 17.
// R10 - Pin activity sensed regardless of pin direction.
// R11 - Software keeps request pins as plain inputs.
// R12 - Internal requests gated by peripheral; priority bits.
// R13 - Transfer-routed timer/serial requests bypass controller.
// R14 - Default order: smaller vector wins; after reset.
// R15 - Priority bits reorder all but NMI.
// R16 - Vector address is four or two times number.
// R17 - Watchdog and refresh share priority A bit 3.
// R18 - Timer channels in groups of four vectors.
// R19 - Transfer end sources 44-47 share B bit 5.
// R20 - Flag set by level/edge; cleared by read-write or ack.
// R21 - Priority bit zero low, one high; reset zero.
// R22 - Global and user mask flags gate levels.
// R23 - Reserved vector numbers are never produced.
//
// Purpose: Collects interrupt sources, prioritises them and presents a vector.
// Assumes: All inputs synchronous to clk_in; peripherals gate their own flags.
// Notes: The presented vector is registered, so it trails a new internal request by one cycle and a new pin request by two.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module isvp_top #(
    parameter int ADDR_W = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic nmi_pin_in,
    input wire logic [5:0] ext_req_n_in,
    input wire logic [29:0] int_req_in,
    input wire logic [29:0] int_to_transfer_in,
    input wire logic global_mask_in,
    input wire logic user_mask_flag_in,
    input wire logic advanced_mode_in,
    input wire logic standby_in,
    input wire logic cpu_ack_in,
    output logic irq_req_out,
    output logic irq_level_out,
    output logic [7:0] vector_num_out,
    output logic [ADDR_W-1:0] vector_addr_out,
    output logic wake_out
);
    // ****************************************
    // Helper functions
    // ****************************************
    // Vector number of internal source index; the table skips reserved slots.
    function automatic logic [7:0] int_vector(input logic [4:0] idx);
        logic [7:0] v;
        logic [7:0] k;
        v = isvp_pkg::VEC_ADC;
        k = {3'h0, idx};
        if (idx == 5'd0) begin
            v = isvp_pkg::VEC_WATCHDOG; // R17
        end else if (idx == 5'd1) begin
            v = isvp_pkg::VEC_REFRESH; // R17
        end else if (idx < 5'd5) begin
            v = isvp_pkg::VEC_TIMER_BASE + (k - 8'd2); // R18
        end else if (idx < 5'd8) begin
            v = isvp_pkg::VEC_TIMER_BASE + 8'd4 + (k - 8'd5); // R18
        end else if (idx < 5'd11) begin
            v = isvp_pkg::VEC_TIMER_BASE + 8'd8 + (k - 8'd8); // R18
        end else if (idx < 5'd14) begin
            v = isvp_pkg::VEC_TIMER_BASE + 8'd12 + (k - 8'd11); // R18
        end else if (idx < 5'd17) begin
            v = isvp_pkg::VEC_TIMER_BASE + 8'd16 + (k - 8'd14); // R18
        end else if (idx < 5'd21) begin
            v = isvp_pkg::VEC_TRANSFER_BASE + (k - 8'd17); // R19
        end else if (idx < 5'd29) begin
            v = isvp_pkg::VEC_SERIAL_BASE + (k - 8'd21);
        end
        return v; // R23
    endfunction

    // Priority level of internal source index from the two priority registers.
    function automatic logic int_level(input logic [4:0] idx, input logic [7:0] pa,
                                       input logic [7:0] pb);
        logic l;
        l = pb[1];
        if (idx < 5'd2) begin
            l = pa[3]; // R17
        end else if (idx < 5'd5) begin
            l = pa[2]; // R18
        end else if (idx < 5'd8) begin
            l = pa[1]; // R18
        end else if (idx < 5'd11) begin
            l = pa[0]; // R18
        end else if (idx < 5'd14) begin
            l = pb[7]; // R18
        end else if (idx < 5'd17) begin
            l = pb[6]; // R18
        end else if (idx < 5'd21) begin
            l = pb[5]; // R19
        end else if (idx < 5'd25) begin
            l = pb[3];
        end else if (idx < 5'd29) begin
            l = pb[2];
        end
        return l; // R12
    endfunction

    // Priority level of external line from priority register A.
    function automatic logic ext_level(input logic [2:0] n, input logic [7:0] pa);
        logic l;
        l = pa[4];
        if (n == 3'd0) begin
            l = pa[7];
        end else if (n == 3'd1) begin
            l = pa[6];
        end else if (n < 3'd4) begin
            l = pa[5];
        end
        return l; // R7
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] system_control_reg;
    logic [7:0] ext_sense_control_reg;
    logic [7:0] ext_line_enable_reg;
    logic [5:0] ext_line_status_reg;
    logic [5:0] status_seen;
    logic [7:0] priority_reg_a;
    logic [7:0] priority_reg_b;
    logic [5:0] ext_pin_prev;
    logic nmi_pin_prev;
    logic nmi_pending;

    wire logic user_mask_enable = system_control_reg[isvp_pkg::BIT_USER_MASK_ENABLE];
    wire logic nmi_edge_select = system_control_reg[isvp_pkg::BIT_NMI_EDGE_SELECT];
    wire logic wr_sys = reg_wr_in && (reg_addr_in == isvp_pkg::OFF_SYSTEM_CONTROL);
    wire logic wr_sense = reg_wr_in && (reg_addr_in == isvp_pkg::OFF_EXT_SENSE);
    wire logic wr_enable = reg_wr_in && (reg_addr_in == isvp_pkg::OFF_EXT_ENABLE);
    wire logic wr_status = reg_wr_in && (reg_addr_in == isvp_pkg::OFF_EXT_STATUS);
    wire logic rd_status = reg_rd_in && (reg_addr_in == isvp_pkg::OFF_EXT_STATUS);
    wire logic wr_pra = reg_wr_in && (reg_addr_in == isvp_pkg::OFF_PRIORITY_A);
    wire logic wr_prb = reg_wr_in && (reg_addr_in == isvp_pkg::OFF_PRIORITY_B);

    // ****************************************
    // Event detection
    // ****************************************
    // The pins are sampled directly, so the port direction set elsewhere never hides them.
    wire logic [5:0] ext_low = ~ext_req_n_in; // R10
    wire logic [5:0] ext_fall = ext_pin_prev & ~ext_req_n_in; // R5
    wire logic [5:0] sense = ext_sense_control_reg[5:0];
    wire logic [5:0] ext_set = (~sense & ext_low) | (sense & ext_fall); // R20
    wire logic nmi_edge = nmi_edge_select ? (nmi_pin_in & ~nmi_pin_prev)
                                          : (~nmi_pin_in & nmi_pin_prev); // R4

    // Acknowledge clears only the line whose vector was being presented.
    logic [5:0] ack_clear;
    always_comb begin
        ack_clear = '0;
        for (int n = 0; n < isvp_pkg::NUM_EXT; n++) begin
            if (cpu_ack_in && irq_req_out &&
                vector_num_out == isvp_pkg::VEC_EXT_BASE + 8'(n)) begin
                // Level lines stay flagged while the pin is still low.
                ack_clear[n] = sense[n] | ext_req_n_in[n]; // R20
            end
        end
    end
    // NMI pending is cleared only when the core takes vector 7 itself.
    wire logic nmi_ack = cpu_ack_in && irq_req_out && vector_num_out == isvp_pkg::VEC_NMI;

    // Software may clear only a flag it has already seen as one.
    wire logic [5:0] sw_clear = wr_status ? (status_seen & ~reg_wdata_in[5:0]) : 6'h00; // R8
    // A new event wins over a clear in the same cycle.
    wire logic [5:0] next_status = (ext_line_status_reg & ~(sw_clear | ack_clear)) | ext_set;
    wire logic next_nmi = (nmi_pending & ~nmi_ack) | nmi_edge;

    // ****************************************
    // Priority selection
    // ****************************************
    // NMI never passes through admit, so the mask flags cannot hold it back.
    function automatic logic admit(input logic lvl, input logic i_flag, input logic ui_flag,
                                   input logic ue);
        logic a;
        a = 1'b1;
        if (i_flag) begin
            a = !ue && !ui_flag && lvl; // R22
        end
        return a;
    endfunction

    // Disabled lines keep their flags, so enabling a line later raises its old request.
    wire logic [5:0] ext_req = ext_line_status_reg & ext_line_enable_reg[5:0]; // R6
    // Routing is honoured only for timer and serial indices; other sources ignore it.
    wire logic [29:0] int_req = int_req_in &
                                ~(int_to_transfer_in & isvp_pkg::ROUTABLE_MASK); // R13

    // Both levels are judged in one pass; within a level the smaller vector stays ahead.
    isvp_pkg::isvp_pick_s pick;
    always_comb begin
        logic lvl;
        lvl = 1'b0;
        pick = '0;
        if (nmi_pending) begin
            pick = '{valid: 1'b1, level: 1'b1, vector: isvp_pkg::VEC_NMI}; // R3
        end else begin
            // Ascending vector scan: a strictly higher level is needed to displace. R14
            for (int n = 0; n < isvp_pkg::NUM_EXT; n++) begin
                lvl = ext_level(3'(n), priority_reg_a); // R21
                if (ext_req[n] && admit(lvl, global_mask_in, user_mask_flag_in,
                                        user_mask_enable) &&
                    (!pick.valid || (lvl && !pick.level))) begin // R15
                    pick = '{valid: 1'b1, level: lvl,
                             vector: isvp_pkg::VEC_EXT_BASE + 8'(n)}; // R9
                end
            end
            for (int k = 0; k < isvp_pkg::NUM_INT; k++) begin
                lvl = int_level(5'(k), priority_reg_a, priority_reg_b); // R21
                if (int_req[k] && admit(lvl, global_mask_in, user_mask_flag_in,
                                        user_mask_enable) &&
                    (!pick.valid || (lvl && !pick.level))) begin // R15
                    pick = '{valid: 1'b1, level: lvl, vector: int_vector(5'(k))}; // R12
                end
            end
        end
    end

    // ****************************************
    // Reserved vector guard
    // ****************************************
    // The source tables never produce a reserved slot; this guard keeps a table slip
    // from ever reaching the core as a live vector.
    function automatic logic is_reserved(input logic [7:0] v);
        logic r;
        r = 1'b0;
        if (v == 8'h12) begin
            r = 1'b1;
        end else if (v == 8'h13) begin
            r = 1'b1;
        end else if (v == 8'h16) begin
            r = 1'b1;
        end else if (v == 8'h17) begin
            r = 1'b1;
        end else if (v == 8'h1b) begin
            r = 1'b1;
        end else if (v == 8'h1f) begin
            r = 1'b1;
        end else if (v == 8'h23) begin
            r = 1'b1;
        end else if (v == 8'h27) begin
            r = 1'b1;
        end else if (v == 8'h2b) begin
            r = 1'b1;
        end else if (v >= 8'h30 && v <= 8'h33) begin
            r = 1'b1;
        end
        return r; // R23
    endfunction

    wire logic next_req = pick.valid && !is_reserved(pick.vector); // R23
    wire logic next_level = next_req && pick.level;
    wire logic [7:0] next_vector = next_req ? pick.vector : 8'h00;

    // Shifting the zero-extended number cannot overflow, since vectors stay below 64.
    wire logic [ADDR_W-1:0] vec_wide = ADDR_W'(next_vector);
    wire logic [ADDR_W-1:0] next_addr = advanced_mode_in ? (vec_wide << 2)
                                                         : (vec_wide << 1); // R16
    // Only NMI and the three lowest lines may end standby.
    wire logic next_wake = standby_in &&
                           (nmi_pending || (ext_line_status_reg[2:0] != 3'h0)); // R2

    // ****************************************
    // Read path
    // ****************************************
    // Unmapped indices read as zero and ignore writes.
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr_in == isvp_pkg::OFF_SYSTEM_CONTROL) begin
            rd_mux = system_control_reg;
        end else if (reg_addr_in == isvp_pkg::OFF_EXT_SENSE) begin
            rd_mux = ext_sense_control_reg;
        end else if (reg_addr_in == isvp_pkg::OFF_EXT_ENABLE) begin
            rd_mux = ext_line_enable_reg;
        end else if (reg_addr_in == isvp_pkg::OFF_EXT_STATUS) begin
            rd_mux = {2'b00, ext_line_status_reg}; // R8
        end else if (reg_addr_in == isvp_pkg::OFF_PRIORITY_A) begin
            rd_mux = priority_reg_a;
        end else if (reg_addr_in == isvp_pkg::OFF_PRIORITY_B) begin
            rd_mux = priority_reg_b;
        end
    end

    wire logic [7:0] next_rdata = reg_rd_in ? rd_mux : 8'h00;

    // Only the two defined control bits are stored; the rest read back as zero.
    wire logic [7:0] sys_mask = 8'h01 << isvp_pkg::BIT_USER_MASK_ENABLE |
                                8'h01 << isvp_pkg::BIT_NMI_EDGE_SELECT;

    // ****************************************
    // State update
    // ****************************************
    // Writes land at the strobe edge, so a read in the next cycle already sees them.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            system_control_reg <= isvp_pkg::RST_SYSTEM_CONTROL;
            ext_sense_control_reg <= isvp_pkg::RST_ZERO;
            ext_line_enable_reg <= isvp_pkg::RST_ZERO;
            priority_reg_a <= isvp_pkg::RST_ZERO; // R21
            priority_reg_b <= isvp_pkg::RST_ZERO; // R14
        end else if (ce_in) begin
            if (wr_sys) begin
                system_control_reg <= reg_wdata_in & sys_mask;
            end
            if (wr_sense) begin
                ext_sense_control_reg <= reg_wdata_in;
            end
            if (wr_enable) begin
                ext_line_enable_reg <= reg_wdata_in;
            end
            if (wr_pra) begin
                priority_reg_a <= reg_wdata_in;
            end
            if (wr_prb) begin
                priority_reg_b <= reg_wdata_in;
            end
        end
    end

    // Edge history resets high, the idle level of the request pins, so release makes no edge.
    // The NMI history resets low, harmless because the reset polarity is the falling edge.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ext_line_status_reg <= 6'h00;
            status_seen <= 6'h00;
            ext_pin_prev <= 6'h3f;
            nmi_pin_prev <= 1'b0;
            nmi_pending <= 1'b0;
        end else if (ce_in) begin
            ext_line_status_reg <= next_status; // R20
            status_seen <= rd_status ? ext_line_status_reg : (status_seen & ~sw_clear);
            ext_pin_prev <= ext_req_n_in;
            nmi_pin_prev <= nmi_pin_in;
            nmi_pending <= next_nmi; // R3
        end
    end

    // Every output is registered, so the core sees one settled vector per cycle.
    // The cost is one cycle of latency from the winning request to irq_req_out.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
            irq_req_out <= 1'b0;
            irq_level_out <= 1'b0;
            vector_num_out <= 8'h00;
            vector_addr_out <= '0;
            wake_out <= 1'b0;
        end else if (ce_in) begin
            reg_rdata_out <= next_rdata;
            irq_req_out <= next_req; // R1
            irq_level_out <= next_level;
            vector_num_out <= next_vector;
            vector_addr_out <= next_addr; // R16
            wake_out <= next_wake;
        end
    end
endmodule

/* verif/isvp_chk.sv */
// Purpose: Port-level assertions for the interrupt source vector prioritizer.
// Assumes: One clock domain; ce_in stays high while checked.
// Notes: Outputs are registered, so input causes are taken one cycle back.
`timescale 1ns/1ps
module isvp_chk #(
    parameter int ADDR_W = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic nmi_pin_in,
    input wire logic [5:0] ext_req_n_in,
    input wire logic [29:0] int_req_in,
    input wire logic [29:0] int_to_transfer_in,
    input wire logic global_mask_in,
    input wire logic user_mask_flag_in,
    input wire logic advanced_mode_in,
    input wire logic standby_in,
    input wire logic cpu_ack_in,
    input wire logic irq_req_out,
    input wire logic irq_level_out,
    input wire logic [7:0] vector_num_out,
    input wire logic [ADDR_W-1:0] vector_addr_out,
    input wire logic wake_out
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_no_read;
        !reg_rd_in;
    endsequence
    AST_RD_IDLE: assert property (s_no_read |=> reg_rdata_out == 8'h00)
        else $error("read data seen outside its slot");
    AST_VEC_ADDR: assert property (irq_req_out |-> vector_addr_out ==
        ($past(advanced_mode_in) ? {vector_num_out, 2'h0} : {1'h0, vector_num_out, 1'h0}))
        else $error("vector address does not match vector number");
    AST_NMI_LEVEL: assert property (vector_num_out == 8'h07 |-> irq_req_out && irq_level_out)
        else $error("vector 7 shown without high level");
    AST_NO_RESERVED: assert property (irq_req_out |-> !(vector_num_out inside
        {8'h12, 8'h13, 8'h16, 8'h17, 8'h1b, 8'h1f, 8'h23, 8'h27, 8'h2b, [8'h30:8'h33]}))
        else $error("reserved vector presented");
    AST_FULL_MASK: assert property ($past(global_mask_in && user_mask_flag_in)
        && irq_req_out |-> vector_num_out == 8'h07)
        else $error("maskable source passed both mask flags");
    AST_MASK_LEVEL: assert property ($past(global_mask_in) && irq_req_out |-> irq_level_out)
        else $error("low level source passed the global mask");
    AST_WAKE_CAUSE: assert property (wake_out |-> $past(standby_in))
        else $error("wake raised outside standby");
    AST_IDLE_VEC: assert property (!irq_req_out |-> vector_num_out == 8'h00
        && vector_addr_out == '0)
        else $error("vector shown with no request");
endmodule

bind isvp_top isvp_chk #(.ADDR_W(ADDR_W)) u_chk (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .nmi_pin_in(nmi_pin_in), .ext_req_n_in(ext_req_n_in),
    .int_req_in(int_req_in), .int_to_transfer_in(int_to_transfer_in),
    .global_mask_in(global_mask_in), .user_mask_flag_in(user_mask_flag_in),
    .advanced_mode_in(advanced_mode_in), .standby_in(standby_in), .cpu_ack_in(cpu_ack_in),
    .irq_req_out(irq_req_out), .irq_level_out(irq_level_out),
    .vector_num_out(vector_num_out), .vector_addr_out(vector_addr_out), .wake_out(wake_out)
);

/* verif/isvp_core_model.sv */
// Purpose: Behavioural processor core that accepts presented vectors.
// Assumes: Acceptance is a one-cycle pulse on the system clock.
// Notes: Slow mode stands for a core that finishes a long instruction first.
`timescale 1ns/1ps
module isvp_core_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ack_en_in,
    input wire logic slow_in,
    input wire logic irq_req_in,
    output logic cpu_ack_out
);
    logic [2:0] wait_cnt;
    logic [2:0] ack_delay;
    // ****************************************
    // Acceptance
    // ****************************************
    // The wait restarts after each pulse, so a request still draining is not taken twice.
    assign ack_delay = slow_in ? 3'h7 : 3'h3;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !ack_en_in || !irq_req_in || cpu_ack_out) begin
            wait_cnt <= 3'h0;
            cpu_ack_out <= 1'b0;
        end else if (wait_cnt == ack_delay) begin
            cpu_ack_out <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 3'h1;
        end
    end
endmodule

/* verif/tb.sv */
// Purpose: Directed bench for the interrupt source vector prioritizer.
// Assumes: Register reads answer one cycle after the strobe.
// Notes: The core model acknowledges only while the bench allows it.
`timescale 1ns/1ps
module tb;
    logic clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic nmi_pin_in = 1'b0, global_mask_in = 1'b0, user_mask_flag_in = 1'b0;
    logic advanced_mode_in = 1'b1, standby_in = 1'b0, ack_en = 1'b0, slow = 1'b0;
    logic [2:0] reg_addr_in = 3'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [5:0] ext_req_n_in = 6'h3f;
    logic [29:0] int_req_in = 30'h0, int_to_transfer_in = 30'h0;
    logic cpu_ack_in, irq_req_out, irq_level_out, wake_out;
    logic [7:0] reg_rdata_out, vector_num_out;
    logic [15:0] vector_addr_out;
    int fail_count = 0, comparisons = 0;
    always #50 clk_in = ~clk_in;
    isvp_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .nmi_pin_in(nmi_pin_in),
        .ext_req_n_in(ext_req_n_in), .int_req_in(int_req_in),
        .int_to_transfer_in(int_to_transfer_in), .global_mask_in(global_mask_in),
        .user_mask_flag_in(user_mask_flag_in), .advanced_mode_in(advanced_mode_in),
        .standby_in(standby_in), .cpu_ack_in(cpu_ack_in), .irq_req_out(irq_req_out),
        .irq_level_out(irq_level_out), .vector_num_out(vector_num_out),
        .vector_addr_out(vector_addr_out), .wake_out(wake_out));
    isvp_core_model i_core (.clk_in(clk_in), .rst_n_in(rst_n_in), .ack_en_in(ack_en),
        .slow_in(slow), .irq_req_in(irq_req_out), .cpu_ack_out(cpu_ack_in));
    // ****************************************
    // Tasks
    // ****************************************
    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= w;
        reg_rd_in <= !w;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        #1;
        if (!w) chk("reg_rdata_out", {8'h00, reg_rdata_out}, {8'h00, d});
    endtask
    // Expected x packs wake, request, level and vector; n edges cover the two-cycle pin path.
    task step(input logic [5:0] e, input logic [29:0] q, input logic [3:0] m, input int n,
              input logic [10:0] x);
        @(posedge clk_in);
        ext_req_n_in <= e;
        int_req_in <= q;
        {nmi_pin_in, global_mask_in, user_mask_flag_in, standby_in} <= m;
        repeat (n) @(posedge clk_in);
        #1;
        chk("wake_req_level_vector", {5'h0, wake_out, irq_req_out, irq_level_out,
            vector_num_out}, {5'h0, x});
        chk("vector_addr_out", vector_addr_out,
            advanced_mode_in ? {6'h0, x[7:0], 2'h0} : {7'h0, x[7:0], 1'h0});
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_in);
        fail_count++;
        finish_test();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 8; i++) bus(1'b0, 3'(i), i == 0 ? 8'h08 : 8'h00);
        bus(1'b1, 3'h0, 8'hff);
        bus(1'b1, 3'h7, 8'hff);
        bus(1'b0, 3'h0, 8'h0c);
        bus(1'b0, 3'h7, 8'h00);
        bus(1'b1, isvp_pkg::OFF_EXT_ENABLE, 8'h3f);
        step(6'h37, 30'h0, 4'h0, 3, 11'h20f);
        @(posedge clk_in);
        advanced_mode_in <= 1'b0;
        step(6'h36, 30'h0, 4'h0, 3, 11'h20c);
        bus(1'b1, isvp_pkg::OFF_PRIORITY_A, 8'h20);
        step(6'h36, 30'h0, 4'h0, 3, 11'h30f);
        bus(1'b0, isvp_pkg::OFF_EXT_STATUS, 8'h09);
        bus(1'b1, isvp_pkg::OFF_EXT_ENABLE, 8'h00);
        step(6'h3f, 30'h0, 4'h0, 3, 11'h000);
        bus(1'b0, isvp_pkg::OFF_EXT_STATUS, 8'h09);
        bus(1'b1, isvp_pkg::OFF_EXT_STATUS, 8'h00);
        bus(1'b0, isvp_pkg::OFF_EXT_STATUS, 8'h00);
        $display("test level lines done");
        bus(1'b1, isvp_pkg::OFF_EXT_SENSE, 8'h3f);
        bus(1'b1, isvp_pkg::OFF_EXT_ENABLE, 8'h3f);
        bus(1'b1, isvp_pkg::OFF_PRIORITY_A, 8'h00);
        step(6'h1f, 30'h0, 4'h0, 3, 11'h211);
        ack_en <= 1'b1;
        step(6'h1f, 30'h0, 4'h0, 10, 11'h000);
        ack_en <= 1'b0;
        slow <= 1'b1;
        step(6'h3f, 30'h0, 4'he, 3, 11'h307);
        ack_en <= 1'b1;
        step(6'h3f, 30'h0, 4'he, 14, 11'h000);
        ack_en <= 1'b0;
        step(6'h3f, 30'h0, 4'h6, 3, 11'h000);
        $display("test edge and nmi done");
        step(6'h3f, 30'h5, 4'h0, 3, 11'h214);
        bus(1'b1, isvp_pkg::OFF_PRIORITY_A, 8'h04);
        step(6'h3f, 30'h5, 4'h0, 3, 11'h318);
        @(posedge clk_in);
        int_to_transfer_in <= 30'h4;
        step(6'h3f, 30'h5, 4'h0, 3, 11'h214);
        bus(1'b1, isvp_pkg::OFF_PRIORITY_A, 8'h08);
        step(6'h3f, 30'h20002, 4'h0, 3, 11'h315);
        bus(1'b1, isvp_pkg::OFF_PRIORITY_B, 8'h20);
        bus(1'b1, isvp_pkg::OFF_PRIORITY_A, 8'h00);
        step(6'h3f, 30'h20002, 4'h0, 3, 11'h32c);
        bus(1'b1, isvp_pkg::OFF_SYSTEM_CONTROL, 8'h04);
        step(6'h3f, 30'h20002, 4'h4, 3, 11'h32c);
        bus(1'b1, isvp_pkg::OFF_PRIORITY_B, 8'h00);
        step(6'h3f, 30'h20002, 4'h4, 3, 11'h000);
        bus(1'b1, isvp_pkg::OFF_PRIORITY_B, 8'h20);
        bus(1'b1, isvp_pkg::OFF_SYSTEM_CONTROL, 8'h0c);
        step(6'h3f, 30'h20002, 4'h4, 3, 11'h000);
        $display("test internal and masks done");
        step(6'h37, 30'h0, 4'h1, 3, 11'h20f);
        step(6'h3d, 30'h0, 4'h1, 3, 11'h60d);
        $display("test standby done");
        finish_test();
    end
endmodule
